// >>> lpmc_pkg.sv
/*
 * Package for the low power mode controller: register map, field
 * positions, reset values, mode states and wake-up timing counts.
 * Assumes a 50 MHz register clock.
 */
package lpmc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_MODE_CTRL2  = 8'h04;
    localparam logic [7:0] ADDR_STATUS      = 8'h08;
    localparam logic [7:0] ADDR_CMD         = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;

    // Mode control fields; the keep-clock bit lies in mode control 2
    localparam int HIGH_CLOCK_SELECT_BIT = 0;
    localparam int IDLE_ON_HALT_BIT      = 1;
    localparam int DIV_SEL_LSB           = 5;
    localparam int DIV_SEL_W             = 3;
    localparam int WDT_ENABLE_BIT        = 8;
    localparam int LVD_ENABLE_BIT        = 9;
    localparam int OSC_IS_RC_BIT         = 10;
    localparam int SYSCLK_KEEP_BIT       = 7;

    // Status fields
    localparam int POWER_DOWN_BIT   = 0;
    localparam int WDT_TIMEOUT_BIT  = 1;
    localparam int FAST_OSC_RDY_BIT = 2;
    localparam int MODE_LSB         = 4;

    // Command fields
    localparam int CMD_HALT_BIT    = 0;
    localparam int CMD_CLR_WDT_BIT = 1;

    // Interrupt status fields
    localparam int IRQ_SLEEP_BIT = 0;
    localparam int IRQ_WAKE_BIT  = 1;
    localparam int IRQ_W         = 2;

    // Reset values and highest divider code for the sub clock
    localparam logic [31:0] MODE_CTRL_RST  = 32'h0000_0101;
    localparam logic [31:0] MODE_CTRL2_RST = 32'h0000_0000;
    localparam logic [2:0]  DIV_SLOW_MAX   = 3'h1;

    // Oscillator settling after wake-up, in register clock (aclk) cycles
    localparam int CRYSTAL_SETTLE_CYCLES = 1024;
    localparam int RC_SETTLE_CYCLES      = 16;
    localparam int SETTLE_CNT_W          = 11;

    localparam int WDT_CNT_W = 18;

    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_DEEP_SLEEP,
        MODE_LIGHT_SLEEP,
        MODE_CLOCK_STOPPED_IDLE,
        MODE_CLOCK_RUNNING_IDLE
    } lpmc_mode_e;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lpmc_pkg

// >>> lpmc_ctrl.sv
/*
 * Low power mode controller: decodes halt into one of four low-power
 * states, gates system and sub clocks, keeps power-down and watchdog
 * timeout flags, collects wake-up sources and paces oscillator ready.
 * Assumes wake inputs come from pins outside this clock domain.
 */
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
// How it works
// R1: fast clock used when high select set or divider code is 010..111.
// R2: software polls oscillator ready before relying on the fast clock.
// R3: halt, idle bit clear, watchdog and detector off gives deep sleep.
// R4: deep sleep stops system and sub clocks, processor held at halt.
// R5: any low-power state leaves memory, registers and ports untouched.
// R6: entering low power sets power-down flag and clears timeout flag.
// R7: deep sleep clears the watchdog counter and keeps it stopped.
// R8: halt, idle bit clear, watchdog or detector on gives light sleep.
// R9: light sleep stops system clock, watchdog and detector run on sub.
// R10: light sleep or idle clears watchdog which then counts on sub clock.
// R11: halt with idle bit set and keep-clock clear gives stopped idle.
// R12: stopped idle stops system clock, keeps sub clock running.
// R13: halt with idle bit set and keep-clock set gives running idle.
// R14: running idle keeps both clocks, processor held at halt.
// R15: wake on external reset, port A falling edge, interrupt, overflow.
// R16: ready flag rises 1024 cycles after wake for crystal, 16 for RC.
// R17: high select clear with divider 000 or 001 selects sub clock.
// R18: halt decoded in one cycle into exactly one low-power state.
module lpmc_ctrl (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Wake-up sources
    input  wire logic        ext_reset_req,
    input  wire logic [7:0]  port_a_in,
    input  wire logic        sys_irq,
    input  wire logic        wdt_tick,
    // Clock gating and status
    output logic             sysclk_en,
    output logic             subclk_en,
    output logic             fast_clk_sel,
    output logic             cpu_hold,
    output logic             wdt_run,
    output logic             irq
);

    lpmc_pkg::lpmc_mode_e mode;
    lpmc_pkg::lpmc_mode_e next_mode;

    logic [31:0] mode_control_reg;
    logic [31:0] mode_control_reg_two;
    logic        power_down_flag;
    logic        watchdog_timeout_flag;
    logic        fast_osc_ready_flag;
    logic [lpmc_pkg::SETTLE_CNT_W-1:0] settle_cnt;
    logic [lpmc_pkg::WDT_CNT_W-1:0]    wdt_cnt;
    logic [lpmc_pkg::IRQ_W-1:0]        irq_status;
    logic [lpmc_pkg::IRQ_W-1:0]        irq_mask;

    // Pin synchronisers
    logic [7:0] pa_s1, pa_s2, pa_prev;
    logic [2:0] ws_s1, ws_s2;
    logic       tick_prev;

    // AXI holding
    logic [7:0]  aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    wire logic       do_write = aw_have && w_have && !s_axi_bvalid;
    wire logic       hit_ctrl = do_write && aw_addr == lpmc_pkg::ADDR_MODE_CTRL;
    wire logic       hit_ctrl2 = do_write && aw_addr == lpmc_pkg::ADDR_MODE_CTRL2;
    wire logic       hit_cmd = do_write && aw_addr == lpmc_pkg::ADDR_CMD;
    wire logic       hit_istat = do_write && aw_addr == lpmc_pkg::ADDR_IRQ_STATUS;
    wire logic       hit_imask = do_write && aw_addr == lpmc_pkg::ADDR_IRQ_MASK;
    wire logic       halt_req = hit_cmd && w_strb[0] && w_data[lpmc_pkg::CMD_HALT_BIT];
    wire logic       clr_wdt = hit_cmd && w_strb[0] && w_data[lpmc_pkg::CMD_CLR_WDT_BIT];

    wire logic [2:0] div_sel = mode_control_reg[lpmc_pkg::DIV_SEL_LSB +: lpmc_pkg::DIV_SEL_W];
    wire logic       idle_on_halt = mode_control_reg[lpmc_pkg::IDLE_ON_HALT_BIT];
    wire logic       wdt_en = mode_control_reg[lpmc_pkg::WDT_ENABLE_BIT];
    wire logic       lvd_en = mode_control_reg[lpmc_pkg::LVD_ENABLE_BIT];
    wire logic       sysclk_keep_in_idle = mode_control_reg_two[lpmc_pkg::SYSCLK_KEEP_BIT];
    wire logic       low_power = mode != lpmc_pkg::MODE_RUN;
    wire logic       port_a_fall = |(pa_prev & ~pa_s2);
    wire logic       ovf = wdt_run && (&wdt_cnt) && ws_s2[2] && !tick_prev;
    // External reset, port A fall, interrupt, watchdog overflow
    wire logic       wake = low_power && (ws_s2[0] || port_a_fall || ws_s2[1] || ovf); // R15

    // Halt decode, one state per cycle of decode
    always_comb begin
        next_mode = mode;
        if (!low_power && halt_req) begin // R18
            if (!idle_on_halt && !wdt_en && !lvd_en) begin
                next_mode = lpmc_pkg::MODE_DEEP_SLEEP; // R3
            end else if (!idle_on_halt) begin
                next_mode = lpmc_pkg::MODE_LIGHT_SLEEP; // R8
            end else if (!sysclk_keep_in_idle) begin
                next_mode = lpmc_pkg::MODE_CLOCK_STOPPED_IDLE; // R11
            end else begin
                next_mode = lpmc_pkg::MODE_CLOCK_RUNNING_IDLE; // R13
            end
        end else if (wake) begin
            next_mode = lpmc_pkg::MODE_RUN;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= lpmc_pkg::MODE_RUN;
        end else if (clk_en) begin
            mode <= next_mode;
        end
    end

    // Synchronisers for pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_s1     <= 8'hff;
            pa_s2     <= 8'hff;
            pa_prev   <= 8'hff;
            ws_s1     <= 3'h0;
            ws_s2     <= 3'h0;
            tick_prev <= 1'b0;
        end else if (clk_en) begin
            pa_s1     <= port_a_in;
            pa_s2     <= pa_s1;
            pa_prev   <= pa_s2;
            ws_s1     <= {wdt_tick, sys_irq, ext_reset_req};
            ws_s2     <= ws_s1;
            tick_prev <= ws_s2[2];
        end
    end

    // Registers; contents are untouched by mode changes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_control_reg     <= lpmc_pkg::MODE_CTRL_RST;
            mode_control_reg_two <= lpmc_pkg::MODE_CTRL2_RST;
            irq_mask             <= '0;
        end else if (clk_en) begin
            if (hit_ctrl) begin
                mode_control_reg <= merge(mode_control_reg, w_data, w_strb); // R5
            end
            if (hit_ctrl2) begin
                mode_control_reg_two <= merge(mode_control_reg_two, w_data, w_strb);
            end
            if (hit_imask && w_strb[0]) begin
                irq_mask <= w_data[lpmc_pkg::IRQ_W-1:0];
            end
        end
    end

    // Power-down and timeout flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down_flag       <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
        end else if (clk_en) begin
            if (next_mode != lpmc_pkg::MODE_RUN && !low_power) begin
                power_down_flag       <= 1'b1; // R6
                watchdog_timeout_flag <= 1'b0; // R6
            end else if (ovf) begin
                watchdog_timeout_flag <= 1'b1;
            end else if (clr_wdt) begin
                power_down_flag       <= 1'b0;
                watchdog_timeout_flag <= 1'b0;
            end
        end
    end

    // Watchdog counter on sub clock ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_cnt <= '0;
        end else if (clk_en) begin
            if ((next_mode != lpmc_pkg::MODE_RUN && !low_power) || clr_wdt || ovf) begin
                wdt_cnt <= '0; // R7 R10
            end else if (wdt_run && ws_s2[2] && !tick_prev) begin
                wdt_cnt <= wdt_cnt + 1'b1; // R10
            end
        end
    end

    // Oscillator ready pacing after wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_osc_ready_flag <= 1'b1;
            settle_cnt          <= '0;
        end else if (clk_en) begin
            if (mode == lpmc_pkg::MODE_DEEP_SLEEP || mode == lpmc_pkg::MODE_LIGHT_SLEEP
                || mode == lpmc_pkg::MODE_CLOCK_STOPPED_IDLE) begin
                fast_osc_ready_flag <= 1'b0;
                settle_cnt <= mode_control_reg[lpmc_pkg::OSC_IS_RC_BIT]
                    ? lpmc_pkg::SETTLE_CNT_W'(lpmc_pkg::RC_SETTLE_CYCLES)
                    : lpmc_pkg::SETTLE_CNT_W'(lpmc_pkg::CRYSTAL_SETTLE_CYCLES); // R16
            end else if (settle_cnt != '0) begin
                settle_cnt <= settle_cnt - 1'b1;
                if (settle_cnt == lpmc_pkg::SETTLE_CNT_W'(1)) begin
                    fast_osc_ready_flag <= 1'b1; // R16
                end
            end
        end
    end

    // Clock gating outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sysclk_en    <= 1'b1;
            subclk_en    <= 1'b1;
            fast_clk_sel <= 1'b1;
            cpu_hold     <= 1'b0;
            wdt_run      <= 1'b0;
        end else if (clk_en) begin
            fast_clk_sel <= mode_control_reg[lpmc_pkg::HIGH_CLOCK_SELECT_BIT]
                || div_sel > lpmc_pkg::DIV_SLOW_MAX; // R1 R17
            cpu_hold     <= next_mode != lpmc_pkg::MODE_RUN; // R4 R14
            sysclk_en    <= next_mode == lpmc_pkg::MODE_RUN
                || next_mode == lpmc_pkg::MODE_CLOCK_RUNNING_IDLE; // R9 R12 R14
            subclk_en    <= next_mode != lpmc_pkg::MODE_DEEP_SLEEP; // R4 R12
            wdt_run      <= next_mode != lpmc_pkg::MODE_DEEP_SLEEP && wdt_en; // R7 R9
        end
    end

    // Sticky interrupts: set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else if (clk_en) begin
            for (int i = 0; i < lpmc_pkg::IRQ_W; i++) begin
                if ((i == lpmc_pkg::IRQ_SLEEP_BIT && next_mode != lpmc_pkg::MODE_RUN
                     && !low_power) || (i == lpmc_pkg::IRQ_WAKE_BIT && wake)) begin
                    irq_status[i] <= 1'b1;
                end else if (hit_istat && w_strb[0] && w_data[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // AXI write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= lpmc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_have && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (hit_ctrl || hit_ctrl2 || hit_cmd || hit_istat || hit_imask)
                    ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= lpmc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= lpmc_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    lpmc_pkg::ADDR_MODE_CTRL:  s_axi_rdata <= mode_control_reg;
                    lpmc_pkg::ADDR_MODE_CTRL2: s_axi_rdata <= mode_control_reg_two;
                    lpmc_pkg::ADDR_STATUS: s_axi_rdata <= {25'h0, 3'(mode), 1'b0,
                        fast_osc_ready_flag, watchdog_timeout_flag, power_down_flag};
                    lpmc_pkg::ADDR_CMD:        s_axi_rdata <= 32'h0000_0000;
                    lpmc_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status};
                    lpmc_pkg::ADDR_IRQ_MASK:   s_axi_rdata <= {30'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= lpmc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : lpmc_ctrl

// >>> lpmc_ctrl_properties.sv
/*
 * Port checker for the low power mode controller: clock gating per
 * state, wake-up latency and read channel behaviour.
 * Assumes one aclk domain and a synchronous active-low aresetn.
 */
`timescale 1ns/10ps
module lpmc_ctrl_properties (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Read channel
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Wake-up sources
    input wire logic        ext_reset_req,
    input wire logic [7:0]  port_a_in,
    input wire logic        sys_irq,
    // Clock gating
    input wire logic        sysclk_en,
    input wire logic        subclk_en,
    input wire logic        cpu_hold,
    input wire logic        wdt_run
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Two sync flops plus detection, then back to running
    sequence s_back_to_run;
        ##[1:6] (!cpu_hold && sysclk_en && subclk_en);
    endsequence

    chk_run_clocks: assert property (!cpu_hold |-> sysclk_en && subclk_en)
        else $error("clocks gated while running");
    chk_deep_stop: assert property (cpu_hold && !subclk_en |-> !sysclk_en && !wdt_run)
        else $error("deep sleep left a clock or watchdog running");
    chk_idle_sub: assert property (cpu_hold && sysclk_en |-> subclk_en)
        else $error("running idle without sub clock");
    chk_irq_wake: assert property (cpu_hold && sys_irq |-> s_back_to_run)
        else $error("interrupt did not wake");
    chk_ext_wake: assert property (cpu_hold && ext_reset_req |-> s_back_to_run)
        else $error("external reset did not wake");
    chk_pin_wake: assert property (
        cpu_hold && |($past(port_a_in) & ~port_a_in) |-> s_back_to_run)
        else $error("port falling edge did not wake");
    chk_read_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data withdrawn early");
    chk_refused_zero: assert property (
        s_axi_rvalid && s_axi_rresp == lpmc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
endmodule : lpmc_ctrl_properties

bind lpmc_ctrl lpmc_ctrl_properties u_props (
    .aclk, .aresetn, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_reset_req, .port_a_in, .sys_irq, .sysclk_en, .subclk_en, .cpu_hold, .wdt_run
);

// >>> lpmc_wake_src.sv
/*
 * Model of the wake-up sources around the core: port A pins with
 * pull-ups, the interrupt line, the reset pin and the sub clock tick.
 * Assumes cpu_hold and subclk_en come from the controller.
 */
`timescale 1ns/10ps
module lpmc_wake_src (
    // Clock and controller state
    input wire logic  aclk,
    input wire logic  cpu_hold,
    input wire logic  subclk_en,
    // Wake-up sources
    output logic [7:0] port_a_in,
    output logic       sys_irq,
    output logic       ext_reset_req,
    output logic       wdt_tick
);
    logic [2:0] div = 3'h0;

    initial begin
        port_a_in = 8'hff;
        sys_irq = 1'b0;
        ext_reset_req = 1'b0;
        wdt_tick = 1'b0;
    end

    // Sub oscillator ticks only while the sub clock runs
    always @(posedge aclk) begin
        div <= div + 3'h1;
        wdt_tick <= subclk_en & div[2];
    end

    // Raise one source and hold it until the core is released
    task automatic wake(input int src, input int b);
        int n;
        n = 0;
        @(posedge aclk);
        case (src)
            0: port_a_in[b] <= 1'b0;
            1: sys_irq <= 1'b1;
            default: ext_reset_req <= 1'b1;
        endcase
        do begin
            @(negedge aclk);
            n++;
        end while (cpu_hold === 1'b1 && n < 20);
        @(posedge aclk);
        port_a_in <= 8'hff;
        sys_irq <= 1'b0;
        ext_reset_req <= 1'b0;
    endtask : wake
endmodule : lpmc_wake_src

// >>> lpmc_ctrl_tb.sv
/*
 * Testbench for the low power mode controller: register bus tasks,
 * mode entry and wake-up per state, interrupts and refusals.
 * Assumes the wake source model and the bound port checker.
 */
`timescale 1ns/10ps
module lpmc_ctrl_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        clk_en = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  port_a_in;
    logic        ext_reset_req, sys_irq, wdt_tick;
    logic        sysclk_en, subclk_en, fast_clk_sel, cpu_hold, wdt_run, irq;
    int          failures = 0;
    int          n_compared = 0;
    logic [31:0] ctl [5] = '{32'h001, 32'h501, 32'h601, 32'h503, 32'h503};
    logic [31:0] c2v [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h80};
    logic [3:0]  ck [5] = '{4'h8, 4'hb, 4'ha, 4'hb, 4'hf};
    logic [2:0]  md [5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4};

    lpmc_ctrl dut (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reset_req,
        .port_a_in, .sys_irq, .wdt_tick, .sysclk_en, .subclk_en, .fast_clk_sel,
        .cpu_hold, .wdt_run, .irq
    );
    lpmc_wake_src wk (
        .aclk, .cpu_hold, .subclk_en, .port_a_in, .sys_irq, .ext_reset_req, .wdt_tick
    );

    always #10 aclk = ~aclk;

    task automatic give_verdict();
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awready;
            w_t = s_axi_wready;
            b_t = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            n++;
        end while (b_t !== 1'b1 && n < 100);
        chk("write answer", 32'h1, {31'h0, b_t});
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar_t, r_t;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar_t = s_axi_arready;
            r_t = s_axi_rvalid;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            n++;
        end while (r_t !== 1'b1 && n < 100);
        chk("read answer", 32'h1, {31'h0, r_t});
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        v = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] r;
        axi_wr(a, v, r);
    endtask : wr

    task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] m, logic [31:0] e);
        logic [31:0] v;
        logic [1:0] r;
        axi_rd(a, v, r);
        chk(nm, e & m, v & m);
    endtask : rd_chk

    task automatic irq_is(input logic e);
        repeat (2) @(negedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_is

    initial begin
        logic [31:0] v;
        logic [1:0] r;
        int n;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("reset outputs", 32'h19, {sysclk_en, subclk_en, cpu_hold, irq, fast_clk_sel});
        rd_chk("mode ctrl", lpmc_pkg::ADDR_MODE_CTRL, '1, lpmc_pkg::MODE_CTRL_RST);
        rd_chk("ctrl two", lpmc_pkg::ADDR_MODE_CTRL2, '1, lpmc_pkg::MODE_CTRL2_RST);
        rd_chk("reset flags", lpmc_pkg::ADDR_STATUS, 32'h3, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr(lpmc_pkg::ADDR_MODE_CTRL, 32'(c) << 5);
            @(negedge aclk);
            chk("fast select", 32'(c > 1), {31'h0, fast_clk_sel});
        end
        for (int i = 0; i < 5; i++) begin
            wr(lpmc_pkg::ADDR_MODE_CTRL, ctl[i]);
            wr(lpmc_pkg::ADDR_MODE_CTRL2, c2v[i]);
            wr(lpmc_pkg::ADDR_CMD, 32'h1);
            @(negedge aclk);
            chk("gating", {28'h0, ck[i]}, {cpu_hold, sysclk_en, subclk_en, wdt_run});
            rd_chk("entry", lpmc_pkg::ADDR_STATUS, 32'h73, {25'h0, md[i], 4'h1});
            wk.wake(i % 3, i);
            rd_chk("woken", lpmc_pkg::ADDR_STATUS, (i == 0) ? 32'h74 : 32'h70, 32'h0);
            n = 0;
            do begin
                axi_rd(lpmc_pkg::ADDR_STATUS, v, r);
                n++;
            end while (v[2] !== 1'b1 && n < 400);
            chk("osc ready", 32'h4, v & 32'h4);
            rd_chk("kept ctrl", lpmc_pkg::ADDR_MODE_CTRL, '1, ctl[i]);
        end
        rd_chk("irq events", lpmc_pkg::ADDR_IRQ_STATUS, 32'h3, 32'h3);
        wr(lpmc_pkg::ADDR_IRQ_MASK, 32'h0);
        irq_is(1'b0);
        wr(lpmc_pkg::ADDR_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(lpmc_pkg::ADDR_IRQ_STATUS, 32'h1);
        irq_is(1'b0);
        rd_chk("irq left", lpmc_pkg::ADDR_IRQ_STATUS, 32'h3, 32'h2);
        wr(lpmc_pkg::ADDR_IRQ_MASK, 32'h3);
        irq_is(1'b1);
        wr(lpmc_pkg::ADDR_IRQ_STATUS, 32'h2);
        irq_is(1'b0);
        wr(lpmc_pkg::ADDR_CMD, 32'h2);
        rd_chk("cleared flags", lpmc_pkg::ADDR_STATUS, 32'h3, 32'h0);
        axi_wr(8'h20, 32'hffff_ffff, r);
        chk("bad write resp", {30'h0, lpmc_pkg::RESP_SLVERR}, {30'h0, r});
        axi_rd(8'h20, v, r);
        chk("bad read resp", {30'h0, lpmc_pkg::RESP_SLVERR}, {30'h0, r});
        chk("bad read data", 32'h0, v);
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge aclk);
        failures++;
        give_verdict();
    end
endmodule : lpmc_ctrl_tb
